/* File: secp_pkg.sv */
// Shared constants and types for the serial EEPROM command port
//------------------------------------------------------------------
//------------------------------------------------------------------
package secp_pkg;
   localparam int unsigned SYS_CLK_MHZ = 25;
   // Mode codes, first bit sent is the MSB
   localparam logic [7:0] MODE_READ = 8'ha8;
   localparam logic [7:0] MODE_WRITE = 8'ha4;
   localparam logic [7:0] MODE_WRITE_EN = 8'ha3;
   localparam logic [7:0] MODE_FORBID_WRITE = 8'ha0;
   localparam logic [7:0] MODE_STATUS = 8'ha9;
   // Status selector, bit 0 is the first address bit sent
   localparam logic [1:0] SEL_BUSY = 2'h0;
   localparam logic [1:0] SEL_PERM = 2'h1;
   localparam logic [1:0] SEL_ECC = 2'h2;
   // Frame bit counts
   localparam logic [5:0] CNT_MODE = 6'h08;
   localparam logic [5:0] CNT_ADDR = 6'h10;
   localparam logic [5:0] CNT_FULL = 6'h20;
   localparam logic [5:0] CNT_STATUS = 6'h11;
   localparam logic PERM_RESET = 1'b1;
   // Times as printed and derived cycle counts
   localparam int unsigned SELF_TIMED_WRITE_TIME_MS = 15;
   localparam int unsigned WRITE_CYC = SELF_TIMED_WRITE_TIME_MS * SYS_CLK_MHZ * 1000;
   localparam int unsigned STATUS_POLL_DELAY_US = 12;
   localparam logic [18:0] POLL_CYC = 19'(STATUS_POLL_DELAY_US * SYS_CLK_MHZ);
   localparam int unsigned SCK_HALF_NS = 450;
   localparam logic [6:0] HALF_CYC = 7'((SCK_HALF_NS * SYS_CLK_MHZ + 999) / 1000);
   localparam int unsigned CLK_HOLD_US = 4;
   localparam logic [6:0] HOLD_CYC = 7'(CLK_HOLD_US * SYS_CLK_MHZ);
   localparam int unsigned SEL_HIGH_US = 4;
   localparam logic [6:0] SELH_CYC = 7'(SEL_HIGH_US * SYS_CLK_MHZ);
   localparam int unsigned SEL_SETUP_US = 1;
   localparam logic [6:0] SETUP_CYC = 7'(SEL_SETUP_US * SYS_CLK_MHZ);

   typedef enum logic [2:0] {
      SECP_OP_READ, SECP_OP_WRITE, SECP_OP_WEN, SECP_OP_WDIS, SECP_OP_STATUS
   } secp_op_type;
endpackage : secp_pkg

/* File: secp_if.sv */
// Link between the serial EEPROM device and its host controller
`timescale 1ns/1ps
interface secp_if;
   logic sck;
   logic sel_n;
   logic serial_in;
   logic serial_out;
   logic wipe;
   logic dev_ready;
   modport dev (input sck, sel_n, serial_in, wipe, output serial_out, dev_ready);
   modport host (output sck, sel_n, serial_in, wipe, input serial_out, dev_ready);
endinterface : secp_if

/* File: secp_device.sv */
// Serial EEPROM device: link sequencer on sck, write engine on sys_clk
`timescale 1ns/1ps
module secp_device
   import secp_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = WRITE_CYC
) (
   secp_if.dev lnk,
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [15:0] cell_upset
);
   //------------------------------------------------------------------
   // State
   //------------------------------------------------------------------
   typedef struct packed {
      logic [5:0] cnt;
      logic [7:0] mode;
      logic [7:0] addr;
      logic [15:0] data;
      logic chain;
   } secp_seq_type;

   typedef struct packed {
      logic tog;
      logic [7:0] mode;
      logic [7:0] addr;
      logic [15:0] data;
      logic chain;
   } secp_req_type;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_s3;
      logic wipe_s1;
      logic wipe_s2;
      logic [15:0] ups_s1;
      logic [15:0] ups_s2;
      logic busy;
      logic [18:0] timer;
      logic [5:0] waddr;
      logic [15:0] wdata;
      logic perm;
      logic ecc;
      logic [15:0] resp;
      logic ready;
      logic [63:0][15:0] mem;
   } secp_core_type;

   secp_seq_type sq_r, sq_nxt;
   secp_req_type rq_r, rq_nxt;
   secp_core_type c_r, c_nxt;
   logic dout_r, dout_nxt;
   logic link_rst;

   // Select high, reset pin or power reset all clear the sequencer
   assign link_rst = lnk.sel_n | lnk.wipe | ~resetn;
   assign lnk.serial_out = dout_r;
   assign lnk.dev_ready = c_r.ready;

   //------------------------------------------------------------------
   // Link sequencer, rising edge of sck
   //------------------------------------------------------------------
   always_comb begin
      sq_nxt = sq_r;
      rq_nxt = rq_r;
      if (sq_r.cnt < CNT_MODE) begin
         sq_nxt.mode = {sq_r.mode[6:0], lnk.serial_in};
      end else if (sq_r.cnt < CNT_ADDR) begin
         sq_nxt.addr[sq_r.cnt[2:0]] = lnk.serial_in;
      end else if (sq_r.cnt < CNT_FULL) begin
         sq_nxt.data[sq_r.cnt[3:0]] = lnk.serial_in;
      end
      if (sq_r.cnt != CNT_FULL) begin
         sq_nxt.cnt = sq_r.cnt + 6'h01;
      end
      // After a write only a status frame may follow without select high
      if (sq_r.cnt == CNT_ADDR - 6'h01 && sq_r.mode != MODE_WRITE &&
          (!sq_r.chain || sq_r.mode == MODE_STATUS)) begin
         rq_nxt.tog = ~rq_r.tog;
         rq_nxt.mode = sq_r.mode;
         rq_nxt.addr = sq_nxt.addr;
         rq_nxt.chain = sq_r.chain;
      end
      if (sq_r.cnt == CNT_FULL - 6'h01 && sq_r.mode == MODE_WRITE && !sq_r.chain) begin
         rq_nxt.tog = ~rq_r.tog;
         rq_nxt.mode = sq_r.mode;
         rq_nxt.addr = sq_r.addr;
         rq_nxt.data = sq_nxt.data;
         rq_nxt.chain = 1'b0;
         // Sequencer restarts itself so status can be polled with select low
         sq_nxt.cnt = 6'h00;
         sq_nxt.mode = 8'h00;
         sq_nxt.chain = 1'b1;
      end
      // Output phase: read word low bit first, or the status bit
      dout_nxt = 1'b1;
      if (sq_r.cnt >= CNT_ADDR && sq_r.cnt < CNT_FULL && sq_r.mode == MODE_READ) begin
         dout_nxt = c_r.resp[sq_r.cnt[3:0]];
      end else if (sq_r.cnt >= CNT_ADDR && sq_r.mode == MODE_STATUS) begin
         dout_nxt = c_r.resp[0];
      end
   end

   always_ff @(posedge lnk.sck or posedge link_rst) begin
      if (link_rst) begin
         sq_r <= '0;
      end else begin
         sq_r <= sq_nxt;
      end
   end

   // Kept apart from the sequencer reset so a select pulse cannot fake an event
   always_ff @(posedge lnk.sck or negedge resetn) begin
      if (!resetn) begin
         rq_r <= '0;
      end else begin
         rq_r <= rq_nxt;
      end
   end

   //------------------------------------------------------------------
   // Serial output, falling edge of sck
   //------------------------------------------------------------------
   always_ff @(negedge lnk.sck or posedge link_rst) begin
      if (link_rst) begin
         dout_r <= 1'b1;
      end else begin
         dout_r <= dout_nxt;
      end
   end

   //------------------------------------------------------------------
   // Write engine and flags, sys_clk
   //------------------------------------------------------------------
   // Request payload is read straight from rq_r: it stays still from the
   // toggle until the next one, which the 4 us byte hold keeps far away.
   always_comb begin
      logic [15:0] word;
      logic [3:0] ones;
      logic corr;
      word = '0;
      ones = '0;
      corr = 1'b0;
      c_nxt = c_r;
      c_nxt.req_s1 = rq_r.tog;
      c_nxt.req_s2 = c_r.req_s1;
      c_nxt.req_s3 = c_r.req_s2;
      c_nxt.wipe_s1 = lnk.wipe;
      c_nxt.wipe_s2 = c_r.wipe_s1;
      c_nxt.ups_s1 = cell_upset;
      c_nxt.ups_s2 = c_r.ups_s1;
      if (c_r.busy) begin
         if (c_r.timer == 19'(WRITE_CYCLES - 1)) begin
            c_nxt.mem[c_r.waddr] = c_r.wdata;
            c_nxt.busy = 1'b0;
         end else begin
            c_nxt.timer = c_r.timer + 19'h00001;
         end
      end
      if (c_r.req_s2 != c_r.req_s3) begin
         case (rq_r.mode)
            MODE_READ: begin
               word = c_r.mem[rq_r.addr[5:0]];
               // A single upset per byte is corrected, more pass through
               for (int b = 0; b < 2; b++) begin
                  ones = 4'($countones(c_r.ups_s2[b*8 +: 8]));
                  if (ones == 4'h1) begin
                     corr = 1'b1;
                  end else if (ones > 4'h1) begin
                     word[b*8 +: 8] = word[b*8 +: 8] ^ c_r.ups_s2[b*8 +: 8];
                  end
               end
               c_nxt.resp = word;
               c_nxt.ecc = corr;
            end
            MODE_WRITE: begin
               if (!c_r.busy && !c_r.perm) begin
                  c_nxt.busy = 1'b1;
                  c_nxt.timer = '0;
                  c_nxt.waddr = rq_r.addr[5:0];
                  c_nxt.wdata = rq_r.data;
               end
            end
            MODE_WRITE_EN: begin
               c_nxt.perm = 1'b0;
            end
            MODE_FORBID_WRITE: begin
               c_nxt.perm = 1'b1;
            end
            MODE_STATUS: begin
               if (!rq_r.chain || !c_r.busy || c_r.timer >= POLL_CYC) begin
                  case (rq_r.addr[1:0])
                     SEL_PERM: c_nxt.resp = {15'h0000, c_r.perm};
                     SEL_ECC: c_nxt.resp = {15'h0000, c_r.ecc};
                     default: c_nxt.resp = {15'h0000, ~c_r.busy};
                  endcase
               end
            end
            default: begin
            end
         endcase
      end
      // Reset pin aborts the write; started writes ignore select
      if (c_r.wipe_s2) begin
         c_nxt.busy = 1'b0;
         c_nxt.timer = '0;
      end
      c_nxt.ready = ~c_nxt.busy;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         c_r <= '0;
         c_r.perm <= PERM_RESET;
      end else if (clk_en) begin
         c_r <= c_nxt;
      end
   end
endmodule : secp_device

/* File: secp_host.sv */
// Host controller: frames commands onto the serial EEPROM link
`timescale 1ns/1ps
module secp_host
   import secp_pkg::*;
(
   secp_if.host lnk,
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic cmd_valid,
   input wire secp_op_type cmd_op,
   input wire logic [5:0] cmd_addr,
   input wire logic [15:0] cmd_wdata,
   input wire logic hold_reset,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic dev_ready
);
   //------------------------------------------------------------------
   // State
   //------------------------------------------------------------------
   typedef enum logic [2:0] {
      H_IDLE, H_SELH, H_SETUP, H_LOW, H_HIGH, H_GAP, H_END, H_WAIT
   } secp_hst_type;

   typedef struct packed {
      secp_hst_type st;
      secp_op_type op;
      logic sel_n;
      logic sck;
      logic sin;
      logic wipe;
      logic rdy;
      logic rsp_v;
      logic [15:0] rsp;
      logic dready;
      logic so_s1;
      logic so_s2;
      logic rb_s1;
      logic rb_s2;
      logic [6:0] tmr;
      logic [31:0] tx;
      logic [5:0] nb;
      logic [5:0] bitn;
   } secp_host_type;

   secp_host_type h_r, h_nxt;

   assign lnk.sck = h_r.sck;
   assign lnk.sel_n = h_r.sel_n;
   assign lnk.serial_in = h_r.sin;
   assign lnk.wipe = h_r.wipe;
   assign cmd_ready = h_r.rdy;
   assign rsp_valid = h_r.rsp_v;
   assign rsp_data = h_r.rsp;
   assign dev_ready = h_r.dready;

   //------------------------------------------------------------------
   // Sequencer; sck is sys_clk divided, data changes while sck is low
   //------------------------------------------------------------------
   always_comb begin
      logic [7:0] af;
      logic [15:0] df;
      logic [7:0] mc;
      logic [5:0] nxb;
      af = '0;
      df = '0;
      mc = MODE_READ;
      nxb = h_r.bitn + 6'h01;
      h_nxt = h_r;
      h_nxt.so_s1 = lnk.serial_out;
      h_nxt.so_s2 = h_r.so_s1;
      h_nxt.rb_s1 = lnk.dev_ready;
      h_nxt.rb_s2 = h_r.rb_s1;
      h_nxt.dready = h_r.rb_s2;
      // Reset pin has its own line, so select never doubles as reset
      h_nxt.wipe = hold_reset;
      h_nxt.rsp_v = 1'b0;
      if (h_r.tmr != 7'h00) begin
         h_nxt.tmr = h_r.tmr - 7'h01;
      end
      case (h_r.st)
         H_IDLE: begin
            h_nxt.rdy = 1'b1;
            if (cmd_valid && h_r.rdy) begin
               // Address and data go out bit 0 first
               for (int i = 0; i < 6; i++) begin
                  af[7 - i] = cmd_addr[i];
               end
               for (int i = 0; i < 16; i++) begin
                  df[15 - i] = cmd_wdata[i];
               end
               h_nxt.nb = CNT_FULL;
               case (cmd_op)
                  SECP_OP_WRITE: mc = MODE_WRITE;
                  SECP_OP_WEN: mc = MODE_WRITE_EN;
                  SECP_OP_WDIS: mc = MODE_FORBID_WRITE;
                  SECP_OP_STATUS: mc = MODE_STATUS;
                  default: mc = MODE_READ;
               endcase
               if (cmd_op == SECP_OP_WEN || cmd_op == SECP_OP_WDIS) begin
                  h_nxt.nb = CNT_ADDR;
               end else if (cmd_op == SECP_OP_STATUS) begin
                  h_nxt.nb = CNT_STATUS;
               end
               h_nxt.tx = {mc, af, df};
               h_nxt.op = cmd_op;
               h_nxt.rdy = 1'b0;
               h_nxt.rsp = '0;
               h_nxt.bitn = '0;
               // Status frames also open with select high: no chained poll
               h_nxt.sel_n = 1'b1;
               h_nxt.tmr = SELH_CYC;
               h_nxt.st = H_SELH;
            end
         end
         H_SELH: begin
            if (h_r.tmr == 7'h00) begin
               h_nxt.sel_n = 1'b0;
               h_nxt.tmr = SETUP_CYC;
               h_nxt.st = H_SETUP;
            end
         end
         H_SETUP, H_GAP: begin
            if (h_r.tmr == 7'h00) begin
               h_nxt.sin = h_r.tx[31];
               h_nxt.tmr = HALF_CYC;
               h_nxt.st = H_LOW;
            end
         end
         H_LOW: begin
            if (h_r.tmr == 7'h00) begin
               h_nxt.sck = 1'b1;
               h_nxt.tmr = HALF_CYC;
               h_nxt.st = H_HIGH;
            end
         end
         H_HIGH: begin
            if (h_r.tmr == 7'h00) begin
               if (h_r.bitn >= CNT_ADDR) begin
                  h_nxt.rsp[h_r.bitn[3:0]] = h_r.so_s2;
               end
               h_nxt.sck = 1'b0;
               h_nxt.bitn = nxb;
               h_nxt.tx = {h_r.tx[30:0], 1'b0};
               if (nxb == h_r.nb) begin
                  h_nxt.tmr = SETUP_CYC;
                  h_nxt.st = H_END;
               end else if (nxb[2:0] == 3'h0) begin
                  h_nxt.tmr = HOLD_CYC;
                  h_nxt.st = H_GAP;
               end else begin
                  h_nxt.sin = h_r.tx[30];
                  h_nxt.tmr = HALF_CYC;
                  h_nxt.st = H_LOW;
               end
            end
         end
         H_END: begin
            if (h_r.tmr == 7'h00) begin
               h_nxt.sel_n = 1'b1;
               h_nxt.tmr = SELH_CYC;
               h_nxt.st = H_WAIT;
            end
         end
         H_WAIT: begin
            // After a write the slot stays closed until the device is ready
            if (h_r.tmr == 7'h00 && (h_r.op != SECP_OP_WRITE || h_r.rb_s2)) begin
               h_nxt.rsp_v = 1'b1;
               h_nxt.rdy = 1'b1;
               h_nxt.st = H_IDLE;
            end
         end
         default: begin
            h_nxt.st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         h_r <= '0;
         h_r.sel_n <= 1'b1;
         h_r.wipe <= 1'b1;
         h_r.sin <= 1'b1;
      end else if (clk_en) begin
         h_r <= h_nxt;
      end
   end
endmodule : secp_host

/* File: secp_properties.sv */
// Link checker for the serial EEPROM command port, host and device ends
`timescale 1ns/1ps
module secp_properties
   import secp_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = WRITE_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic sck,
   input wire logic sel_n,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic wipe,
   input wire logic dev_ready
);
   //---------------------------------------------------------------
   // Helper logic
   //---------------------------------------------------------------
   // Margin covers the resync flops between the engine and the pin
   // Counted, not a delay range: the full write time is far beyond one
   localparam int BUSY_MAX = WRITE_CYCLES + 16;
   logic sck_r;
   logic [5:0] rise_r;
   logic [19:0] busy_r;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sck_r <= 1'b0;
         rise_r <= 6'h00;
         busy_r <= 20'h00000;
      end else begin
         sck_r <= sck;
         if (dev_ready || wipe) begin
            busy_r <= 20'h00000;
         end else if (busy_r != 20'hfffff) begin
            busy_r <= busy_r + 20'h00001;
         end
         if (sel_n) begin
            rise_r <= 6'h00;
         end else if (sck && !sck_r) begin
            rise_r <= rise_r + 6'h01;
         end
      end
   end
   //---------------------------------------------------------------
   // Properties
   //---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_write_start;
      $fell(dev_ready);
   endsequence
   sequence s_frame_end;
      $rose(sel_n) && !wipe;
   endsequence
   property p_sck_idle;
      sel_n |-> !sck;
   endproperty
   a_sck_idle: assert property (p_sck_idle)
      else $error("link clock moved while deselected");
   property p_din_stable;
      $rose(sck) |-> $stable(serial_in);
   endproperty
   a_din_stable: assert property (p_din_stable)
      else $error("serial_in changed at the sampling edge");
   property p_out_on_fall;
      $changed(serial_out) |-> !sck || sel_n || wipe;
   endproperty
   a_out_on_fall: assert property (p_out_on_fall)
      else $error("serial_out changed while the link clock was high");
   property p_out_idle;
      $rose(sel_n) |-> ##[1:25] serial_out;
   endproperty
   a_out_idle: assert property (p_out_idle)
      else $error("serial_out not idle after deselect");
   property p_frame_len;
      s_frame_end |-> rise_r == CNT_ADDR || rise_r == CNT_STATUS || rise_r == CNT_FULL;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame length not 16, 17 or 32 bits");
   property p_sel_gap;
      $rose(sel_n) |-> sel_n[*8];
   endproperty
   a_sel_gap: assert property (p_sel_gap)
      else $error("select high pulse too short");
   property p_busy_cause;
      s_write_start |-> !sel_n && !wipe;
   endproperty
   a_busy_cause: assert property (p_busy_cause)
      else $error("busy without a write frame");
   property p_busy_max;
      busy_r <= 20'(BUSY_MAX);
   endproperty
   a_busy_max: assert property (p_busy_max)
      else $error("write not finished in time");
   property p_busy_min;
      s_write_start |-> (!dev_ready || wipe)[*8];
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("write ended early");
   property p_abort;
      wipe && !dev_ready |-> ##[1:8] dev_ready;
   endproperty
   a_abort: assert property (p_abort)
      else $error("reset pin did not abort the write");
endmodule : secp_properties

/* File: tb_top.sv */
// Self-checking bench: host and device joined across the link
`timescale 1ns/1ps
module tb_top
   import secp_pkg::*;
;
   //---------------------------------------------------------------
   // Signals and instances
   //---------------------------------------------------------------
   // Short write time keeps the run small and lets each write end inside the 4000-cycle wait of do_cmd
   localparam int unsigned W_CYC = 200;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid = 1'b0;
   secp_op_type cmd_op = SECP_OP_READ;
   logic [5:0] cmd_addr = 6'h00;
   logic [15:0] cmd_wdata = 16'h0000;
   logic hold_reset = 1'b0;
   logic clk_en = 1'b1;
   logic freeze_on = 1'b0;
   logic sck_seen;
   logic [15:0] cell_upset = 16'h0000;
   logic cmd_ready;
   logic rsp_valid;
   logic h_ready;
   logic [15:0] rsp_data;
   logic [15:0] got;
   logic busy_seen;
   logic [31:0] wbits;
   int nbits = 0;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   secp_if lnk();
   secp_device #(.WRITE_CYCLES(W_CYC)) secp_device_inst (.lnk(lnk.dev), .sys_clk(sys_clk),
      .resetn(resetn), .clk_en(clk_en), .cell_upset(cell_upset));
   secp_host secp_host_inst (.lnk(lnk.host), .sys_clk(sys_clk), .resetn(resetn),
      .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .hold_reset(hold_reset), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dev_ready(h_ready));
   secp_properties #(.WRITE_CYCLES(W_CYC)) secp_properties_inst (.sys_clk(sys_clk),
      .resetn(resetn), .sck(lnk.sck), .sel_n(lnk.sel_n), .serial_in(lnk.serial_in),
      .serial_out(lnk.serial_out), .wipe(lnk.wipe), .dev_ready(lnk.dev_ready));
   always #20 sys_clk = ~sys_clk;
   always @(negedge lnk.sel_n) nbits = 0;
   always @(posedge lnk.sck) begin
      if (lnk.sel_n === 1'b0 && nbits < 32) begin
         wbits[nbits] = lnk.serial_in;
         nbits = nbits + 1;
      end
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total = err_total + 1;
         report_and_stop();
      end
   end
   //---------------------------------------------------------------
   // Shared tasks
   //---------------------------------------------------------------
   task automatic report_and_stop;
      $display("TB counts: checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      check_count = check_count + 1;
      if (exp !== seen) begin
         err_total = err_total + 1;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Abort raises the reset pin once the device reports busy
   task automatic do_cmd(input secp_op_type op, input logic [5:0] addr,
         input logic [15:0] wd, input logic abort);
      int n;
      n = 0;
      busy_seen = 1'b0;
      while (cmd_ready !== 1'b1 && n < 4000) begin
         @(negedge sys_clk);
         n = n + 1;
      end
      cmd_op = op;
      cmd_addr = addr;
      cmd_wdata = wd;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 4000) begin
         @(negedge sys_clk);
         n = n + 1;
         if (lnk.dev_ready === 1'b0) begin
            busy_seen = 1'b1;
            hold_reset = abort;
         end
         if (freeze_on && n == 300) begin
            sck_seen = lnk.sck;
            clk_en = 1'b0;
            repeat (40) @(negedge sys_clk);
            chk("sck while frozen", {15'h0000, sck_seen}, {15'h0000, lnk.sck});
            clk_en = 1'b1;
         end
      end
      if (rsp_valid !== 1'b1) begin
         err_total = err_total + 1;
         report_and_stop();
      end
      got = rsp_data;
      hold_reset = 1'b0;
   endtask : do_cmd
   task automatic stat(input logic [1:0] sel, input logic exp, input string what);
      do_cmd(SECP_OP_STATUS, {4'h0, sel}, 16'h0000, 1'b0);
      chk(what, {15'h0000, exp}, {15'h0000, got[0]});
   endtask : stat
   //---------------------------------------------------------------
   // Scenarios
   //---------------------------------------------------------------
   task automatic t_reset_state;
      stat(SEL_PERM, PERM_RESET, "perm after reset");
      stat(SEL_BUSY, 1'b1, "ready when idle");
   endtask : t_reset_state
   task automatic t_write_read;
      logic [5:0] ta [3] = '{6'h2a, 6'h00, 6'h3f};
      logic [15:0] td [3] = '{16'h5a3c, 16'hffff, 16'h8001};
      logic [15:0] hdr;
      do_cmd(SECP_OP_WEN, 6'h15, 16'h0000, 1'b0);
      stat(SEL_PERM, 1'b0, "perm after enable");
      for (int k = 0; k < 3; k++) begin
         do_cmd(SECP_OP_WRITE, ta[k], td[k], 1'b0);
         chk("busy during write", 16'h0001, {15'h0000, busy_seen});
         do_cmd(SECP_OP_READ, ta[k], 16'h0000, 1'b0);
         chk("read word", td[k], got);
      end
      for (int i = 0; i < 16; i++) begin
         if (i < 8) begin
            hdr[i] = MODE_READ[7 - i];
         end else if (i < 14) begin
            hdr[i] = ta[2][i - 8];
         end else begin
            hdr[i] = 1'b0;
         end
      end
      chk("read header bits", hdr, wbits[15:0]);
   endtask : t_write_read
   task automatic t_forbid;
      do_cmd(SECP_OP_WDIS, 6'h00, 16'h0000, 1'b0);
      stat(SEL_PERM, 1'b1, "perm after disable");
      do_cmd(SECP_OP_WRITE, 6'h2a, 16'h1111, 1'b0);
      chk("busy on refused write", 16'h0000, {15'h0000, busy_seen});
      do_cmd(SECP_OP_READ, 6'h2a, 16'h0000, 1'b0);
      chk("word kept", 16'h5a3c, got);
   endtask : t_forbid
   task automatic t_abort;
      do_cmd(SECP_OP_WEN, 6'h00, 16'h0000, 1'b0);
      do_cmd(SECP_OP_WRITE, 6'h2a, 16'h0ff0, 1'b1);
      chk("busy before abort", 16'h0001, {15'h0000, busy_seen});
      do_cmd(SECP_OP_READ, 6'h2a, 16'h0000, 1'b0);
      chk("word after abort", 16'h5a3c, got);
      stat(SEL_BUSY, 1'b1, "ready after abort");
      chk("host ready view", 16'h0001, {15'h0000, h_ready});
   endtask : t_abort
   task automatic t_ecc;
      cell_upset = 16'h0101;
      do_cmd(SECP_OP_READ, 6'h2a, 16'h0000, 1'b0);
      chk("corrected word", 16'h5a3c, got);
      stat(SEL_ECC, 1'b1, "correction set");
      cell_upset = 16'h0300;
      do_cmd(SECP_OP_READ, 6'h2a, 16'h0000, 1'b0);
      chk("double upset word", 16'h593c, got);
      cell_upset = 16'h0000;
      do_cmd(SECP_OP_READ, 6'h2a, 16'h0000, 1'b0);
      stat(SEL_ECC, 1'b0, "correction clear");
   endtask : t_ecc
   task automatic t_freeze;
      freeze_on = 1'b1;
      do_cmd(SECP_OP_READ, 6'h2a, 16'h0000, 1'b0);
      freeze_on = 1'b0;
      chk("read across freeze", 16'h5a3c, got);
   endtask : t_freeze
   initial begin
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1'b1;
      t_reset_state();
      t_write_read();
      t_forbid();
      t_abort();
      t_ecc();
      t_freeze();
      report_and_stop();
   end
endmodule : tb_top
